/* verilog/pmi_pkg.sv */
// Shared constants and types of the power monitor two-wire serial front end.
package pmi_pkg;
    // ==========================================================
    // Address layout
    localparam logic [2:0] PMI_ADDR_FIXED = 3'h4;
    localparam int PMI_ADDR_BITS = 7;
    // ==========================================================
    // Command byte layout
    localparam int PMI_CMD_EXT_BIT = 7;
    localparam logic [7:0] PMI_CMD_RESET = 8'h00;
    // ==========================================================
    // Conversion results
    localparam int PMI_RES_BITS = 12;
    localparam logic [11:0] PMI_RES_RESET = 12'h000;
    // ==========================================================
    // Bus timing at 40 MHz system clock
    localparam int PMI_CLK_MHZ = 40;
    localparam int PMI_SCL_KHZ = 400;
    localparam int PMI_HALF_NS = 1250;
    localparam int PMI_HALF_CYC = (PMI_HALF_NS * PMI_CLK_MHZ) / 1000;
    localparam logic [3:0] PMI_BITS_PER_UNIT = 4'h9;
    // ==========================================================
    // Master command codes
    typedef enum logic [1:0] {
        PMI_OP_QUICK = 2'h0,
        PMI_OP_WRITE = 2'h1,
        PMI_OP_READ = 2'h2
    } pmi_op_type;
    // ==========================================================
    // Slave states
    typedef enum logic [2:0] {
        PMI_S_IDLE = 3'h0,
        PMI_S_ADDR = 3'h1,
        PMI_S_ACK = 3'h2,
        PMI_S_RX = 3'h3,
        PMI_S_TX = 3'h4,
        PMI_S_RACK = 3'h5
    } pmi_sst_type;
    // ==========================================================
    // Master states
    typedef enum logic [2:0] {
        PMI_M_IDLE = 3'h0,
        PMI_M_START = 3'h1,
        PMI_M_LOW = 3'h2,
        PMI_M_HIGH = 3'h3,
        PMI_M_STOP0 = 3'h4,
        PMI_M_STOP1 = 3'h5,
        PMI_M_DONE = 3'h6
    } pmi_mst_type;
endpackage

/* verilog/pmi_bus_if.sv */
// Two-wire serial bus between the monitor slave and the bus master.
`timescale 1ns/1ps
interface pmi_bus_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    wire scl_line;
    wire sda_line;
    // ==========================================================
    // Open-drain wired-and; a released line floats high by pull-up.
    assign scl_line = !(scl_oe && !scl_o);
    assign sda_line = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
    modport slave (input scl_line, input sda_line, output sda_s_o, output sda_s_oe);
    modport master (input scl_line, input sda_line, output scl_o, output scl_oe, output sda_m_o, output sda_m_oe);
endinterface

/* verilog/pmi_slave.sv */
// Monitor end: two-wire slave with address straps, command capture and result readback.
`timescale 1ns/1ps
// Contract
// - Address top three bits fixed 100.
// - Straps give low four address bits.
// - Two two-bit straps give sixteen distinct addresses.
// - Start is falling data, clock high.
// - Address byte MSB first, then direction.
// - Acknowledge low around ninth clock on match, except a read while results are not ready.
// - Mismatch keeps line released until start.
// - Unit is eight bits plus acknowledge.
// - Master changes data only while clock low.
// - Rising data, clock high is stop.
// - First written byte is the command.
// - Master writes command before reading.
// - Write ends with stop after acknowledge.
// - Master not-acknowledges last read byte, stops.
// - Works at 400 kHz bus clock.
// - Voltage or current results, conversions anytime.
// - Reads return results in two/three bytes.
// - Command MSB one means extended write.
// - Presence check is address-only write.
module pmi_slave
    import pmi_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    pmi_bus_if.slave bus,
    input wire logic [1:0] addr_strap_low,
    input wire logic [1:0] addr_strap_high,
    input wire logic [11:0] volt_result,
    input wire logic [11:0] curr_result,
    input wire logic results_ready,
    output logic [7:0] cmd_byte,
    output logic cmd_strobe,
    output logic ext_strobe,
    output logic [7:0] ext_data,
    output logic ext_data_strobe
);
    logic [2:0] scl_sync_r;
    logic [2:0] sda_sync_r;
    logic [1:0] strap_lo_r;
    logic [1:0] strap_hi_r;
    logic [3:0] strap_s1_r;
    logic [3:0] strap_s2_r;
    logic [1:0] strap_wait_r;
    logic [6:0] own_addr;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    pmi_sst_type state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic rw_r;
    logic [23:0] tx_buf_r;
    logic sda_oe_r;
    logic [7:0] cmd_r;
    logic cmd_stb_r;
    logic ext_stb_r;
    logic ext_mode_r;
    logic [7:0] ext_data_r;
    logic ext_dstb_r;

    // ==========================================================
    // Line synchronisers; only the second and third stages feed logic.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_sync_r <= 3'h7;
            sda_sync_r <= 3'h7;
        end else begin
            scl_sync_r <= {scl_sync_r[1:0], bus.scl_line};
            sda_sync_r <= {sda_sync_r[1:0], bus.sda_line};
        end
    end
    assign scl_rise = scl_sync_r[1] && !scl_sync_r[2];
    assign scl_fall = !scl_sync_r[1] && scl_sync_r[2];
    assign start_det = scl_sync_r[1] && scl_sync_r[2] && !sda_sync_r[1] && sda_sync_r[2];
    assign stop_det = scl_sync_r[1] && scl_sync_r[2] && sda_sync_r[1] && !sda_sync_r[2];

    // ==========================================================
    // Strap pins pass two flip-flops and are captured once after reset release.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_s1_r <= 4'h0;
            strap_s2_r <= 4'h0;
            strap_wait_r <= 2'h0;
            strap_lo_r <= 2'h0;
            strap_hi_r <= 2'h0;
        end else begin
            strap_s1_r <= {addr_strap_high, addr_strap_low};
            strap_s2_r <= strap_s1_r;
            if (strap_wait_r != 2'h3) begin
                strap_wait_r <= strap_wait_r + 2'h1;
            end
            if (strap_wait_r == 2'h2) begin
                strap_lo_r <= strap_s2_r[1:0];
                strap_hi_r <= strap_s2_r[3:2];
            end
        end
    end
    assign own_addr = {PMI_ADDR_FIXED, strap_hi_r, strap_lo_r};

    // ==========================================================
    // Bus state machine.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= PMI_S_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            rw_r <= 1'b0;
            sda_oe_r <= 1'b0;
            tx_buf_r <= 24'h000000;
        end else if (start_det) begin
            state_r <= PMI_S_ADDR;
            bit_cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= PMI_S_IDLE;
            sda_oe_r <= 1'b0;
        end else begin
            unique case (state_r)
                PMI_S_IDLE: begin
                    sda_oe_r <= 1'b0;
                end
                PMI_S_ADDR, PMI_S_RX: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_sync_r[1]};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall && bit_cnt_r == 4'h8) begin
                        bit_cnt_r <= 4'h0;
                        if (state_r == PMI_S_ADDR && shift_r[7:1] != own_addr) begin
                            state_r <= PMI_S_IDLE;
                        end else begin
                            sda_oe_r <= 1'b1;
                            state_r <= PMI_S_ACK;
                            if (state_r == PMI_S_ADDR) begin
                                rw_r <= shift_r[0];
                                tx_buf_r <= {volt_result, curr_result};
                                if (shift_r[0] && !results_ready) begin
                                    sda_oe_r <= 1'b0;
                                    state_r <= PMI_S_IDLE;
                                end
                            end
                        end
                    end
                end
                PMI_S_ACK: begin
                    if (scl_fall) begin
                        if (rw_r) begin
                            sda_oe_r <= !tx_buf_r[23];
                            state_r <= PMI_S_TX;
                        end else begin
                            sda_oe_r <= 1'b0;
                            state_r <= PMI_S_RX;
                        end
                    end
                end
                PMI_S_TX: begin
                    if (scl_fall) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == 4'h7) begin
                            sda_oe_r <= 1'b0;
                            state_r <= PMI_S_RACK;
                        end else begin
                            sda_oe_r <= !tx_buf_r[22];
                            tx_buf_r <= {tx_buf_r[22:0], 1'b0};
                        end
                    end
                end
                PMI_S_RACK: begin
                    if (scl_rise) begin
                        bit_cnt_r <= 4'h0;
                        tx_buf_r <= {tx_buf_r[22:0], 1'b0};
                        if (sda_sync_r[1]) begin
                            state_r <= PMI_S_IDLE;
                        end
                    end else if (scl_fall) begin
                        sda_oe_r <= !tx_buf_r[23];
                        state_r <= PMI_S_TX;
                    end
                end
                default: begin
                    state_r <= PMI_S_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Command and extended byte capture on each received data byte.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_r <= PMI_CMD_RESET;
            cmd_stb_r <= 1'b0;
            ext_stb_r <= 1'b0;
            ext_mode_r <= 1'b0;
            ext_data_r <= 8'h00;
            ext_dstb_r <= 1'b0;
        end else begin
            cmd_stb_r <= 1'b0;
            ext_stb_r <= 1'b0;
            ext_dstb_r <= 1'b0;
            if (state_r == PMI_S_ADDR && scl_fall && bit_cnt_r == 4'h8) begin
                ext_mode_r <= 1'b0;
            end else if (state_r == PMI_S_RX && scl_fall && bit_cnt_r == 4'h8) begin
                if (ext_mode_r) begin
                    ext_data_r <= shift_r;
                    ext_dstb_r <= 1'b1;
                    ext_mode_r <= 1'b0;
                end else begin
                    cmd_r <= shift_r;
                    if (shift_r[PMI_CMD_EXT_BIT]) begin
                        ext_stb_r <= 1'b1;
                        ext_mode_r <= 1'b1;
                    end else begin
                        cmd_stb_r <= 1'b1;
                    end
                end
            end
        end
    end

    assign bus.sda_s_o = 1'b0;
    assign bus.sda_s_oe = sda_oe_r;
    assign cmd_byte = cmd_r;
    assign cmd_strobe = cmd_stb_r;
    assign ext_strobe = ext_stb_r;
    assign ext_data = ext_data_r;
    assign ext_data_strobe = ext_dstb_r;
endmodule

/* verilog/pmi_master.sv */
// Bus master end: issues presence check, command write and result read transactions.
`timescale 1ns/1ps
module pmi_master
    import pmi_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    pmi_bus_if.master bus,
    input wire logic req_valid,
    input wire pmi_op_type req_op,
    input wire logic [6:0] req_addr,
    input wire logic [7:0] req_cmd,
    input wire logic [1:0] req_len,
    output logic busy,
    output logic done,
    output logic nack,
    output logic [23:0] rd_data
);
    pmi_mst_type state_r;
    logic [7:0] div_r;
    logic [3:0] bit_r;
    logic [1:0] units_r;
    logic [1:0] left_r;
    logic [7:0] tx_r;
    logic [23:0] rx_r;
    logic rd_r;
    logic scl_r;
    logic sda_r;
    logic busy_r;
    logic done_r;
    logic nack_r;
    logic [1:0] sda_sync_r;
    logic tick;

    assign tick = (div_r == 8'(PMI_HALF_CYC - 1));

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_sync_r <= 2'h3;
        end else begin
            sda_sync_r <= {sda_sync_r[0], bus.sda_line};
        end
    end

    // ==========================================================
    // Half-period divider and transaction sequencer.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= PMI_M_IDLE;
            div_r <= 8'h00;
            bit_r <= 4'h0;
            units_r <= 2'h0;
            left_r <= 2'h0;
            tx_r <= 8'h00;
            rx_r <= 24'h000000;
            rd_r <= 1'b0;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            nack_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            div_r <= (state_r == PMI_M_IDLE || tick) ? 8'h00 : div_r + 8'h01;
            unique case (state_r)
                PMI_M_IDLE: begin
                    if (req_valid) begin
                        busy_r <= 1'b1;
                        nack_r <= 1'b0;
                        rd_r <= (req_op == PMI_OP_READ);
                        tx_r <= {req_addr, req_op == PMI_OP_READ};
                        units_r <= (req_op == PMI_OP_WRITE) ? req_len + 2'h2 : ((req_op == PMI_OP_READ) ? req_len + 2'h1 : 2'h1);
                        left_r <= 2'h0;
                        state_r <= PMI_M_START;
                    end
                end
                PMI_M_START: begin
                    if (tick) begin
                        sda_r <= 1'b0;
                        state_r <= PMI_M_LOW;
                        bit_r <= 4'h0;
                    end
                end
                PMI_M_LOW: begin
                    if (tick) begin
                        if (scl_r) begin
                            scl_r <= 1'b0;
                        end else begin
                            scl_r <= 1'b1;
                            state_r <= PMI_M_HIGH;
                        end
                    end else if (!scl_r && div_r == 8'h00) begin
                        if (bit_r < 4'h8) begin
                            sda_r <= (rd_r && left_r != 2'h0) ? 1'b1 : tx_r[7];
                        end else begin
                            sda_r <= !(rd_r && left_r != 2'h0 && units_r != 2'h1);
                        end
                    end
                end
                PMI_M_HIGH: begin
                    if (tick) begin
                        bit_r <= bit_r + 4'h1;
                        if (bit_r < 4'h8) begin
                            tx_r <= {tx_r[6:0], 1'b0};
                            rx_r <= {rx_r[22:0], sda_sync_r[1]};
                            state_r <= PMI_M_LOW;
                        end else begin
                            bit_r <= 4'h0;
                            units_r <= units_r - 2'h1;
                            if (left_r == 2'h0 && sda_sync_r[1]) begin
                                nack_r <= 1'b1;
                                units_r <= 2'h0;
                            end
                            tx_r <= req_cmd;
                            left_r <= left_r + 2'h1;
                            state_r <= (units_r == 2'h1 || (left_r == 2'h0 && sda_sync_r[1])) ? PMI_M_STOP0 : PMI_M_LOW;
                        end
                        scl_r <= 1'b0;
                    end
                end
                PMI_M_STOP0: begin
                    if (tick) begin
                        scl_r <= 1'b1;
                        state_r <= PMI_M_STOP1;
                    end else if (div_r == 8'h00) begin
                        sda_r <= 1'b0;
                    end
                end
                PMI_M_STOP1: begin
                    if (tick) begin
                        sda_r <= 1'b1;
                        state_r <= PMI_M_DONE;
                    end
                end
                PMI_M_DONE: begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    state_r <= PMI_M_IDLE;
                end
                default: begin
                    state_r <= PMI_M_IDLE;
                end
            endcase
        end
    end

    assign bus.scl_o = 1'b0;
    assign bus.scl_oe = !scl_r;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = !sda_r;
    assign busy = busy_r;
    assign done = done_r;
    assign nack = nack_r;
    assign rd_data = rx_r;
endmodule

/* test/pmi_bus_checker.sv */
// Concurrent checks on the two-wire bus between the monitor slave and the bus master.
`timescale 1ns/1ps
module pmi_bus_checker (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic scl_line,
    input wire logic sda_line
);
    // ==========================================================
    // Bus event tracking.
    logic scl_d_r;
    logic sda_d_r;
    logic idle_r;
    logic [4:0] cnt_r;
    wire start_w = scl_d_r && scl_line && sda_d_r && !sda_line;
    wire stop_w = scl_d_r && scl_line && !sda_d_r && sda_line;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_line;
            sda_d_r <= sda_line;
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            idle_r <= 1'b1;
        end else if (start_w) begin
            idle_r <= 1'b0;
        end else if (stop_w) begin
            idle_r <= 1'b1;
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 5'h1f;
        end else if (start_w) begin
            cnt_r <= 5'h00;
        end else if (!scl_d_r && scl_line && cnt_r != 5'h1f) begin
            cnt_r <= cnt_r + 5'h01;
        end
    end
    // ==========================================================
    // Assertions.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    AST_SLV_EDGE_LOW: assert property ($changed(sda_s_oe) |-> !scl_line)
        else $error("slave data drive changed while clock high");
    AST_ACK_HOLD: assert property ($rose(scl_line) && sda_s_oe |-> sda_s_oe [*8])
        else $error("slave released data during clock high");
    AST_SLV_OPEN_DRAIN: assert property (sda_s_oe |-> !sda_s_o)
        else $error("slave drives data high");
    AST_MST_OPEN_DRAIN: assert property (!((scl_oe && scl_o) || (sda_m_oe && sda_m_o)))
        else $error("master drives a line high");
    AST_IDLE_RELEASED: assert property (idle_r |-> !sda_s_oe)
        else $error("slave drives data after stop");
    AST_ADDR_NO_DRIVE: assert property (cnt_r <= 5'h08 && scl_d_r && scl_line |-> !sda_s_oe)
        else $error("slave drives data during address bits");
    AST_ADDR_STABLE: assert property (cnt_r >= 5'h01 && cnt_r <= 5'h08 && scl_d_r && scl_line |-> $stable(sda_line))
        else $error("data changed while clock high in address byte");
    AST_START_BY_MASTER: assert property (start_w |-> sda_m_oe && !sda_s_oe)
        else $error("start condition not made by master");
    cover property (start_w);
    cover property (stop_w);
    cover property ($rose(scl_line) && sda_s_oe && cnt_r == 5'h08);
endmodule

/* test/power_monitor_i2c_slave_front_end_tb.sv */
// Self-checking testbench joining the monitor slave and the bus master.
`timescale 1ns/1ps
module power_monitor_i2c_slave_front_end_tb import pmi_pkg::*;;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] addr_strap_low = 2'h0;
    logic [1:0] addr_strap_high = 2'h0;
    logic [11:0] volt_result = 12'h000;
    logic [11:0] curr_result = 12'h000;
    logic results_ready = 1'b0;
    logic req_valid = 1'b0;
    pmi_op_type req_op = PMI_OP_QUICK;
    logic [6:0] req_addr = 7'h00;
    logic [7:0] req_cmd = 8'h00;
    logic [1:0] req_len = 2'h0;
    logic [7:0] cmd_byte;
    logic cmd_strobe;
    logic ext_strobe;
    logic [7:0] ext_data;
    logic ext_data_strobe;
    logic busy;
    logic done;
    logic nack;
    logic [23:0] rd_data;
    logic scl_d = 1'b1;
    logic sda_d = 1'b1;
    logic [7:0] mon_sh = 8'h00;
    logic mon_ack = 1'b1;
    int mon_cnt = 99;
    int cmd_cnt = 0;
    int ext_cnt = 0;
    int ext_d_cnt = 0;
    int err_count = 0;
    int total_checks = 0;
    // ==========================================================
    // Clock and design.
    always #12.5 sys_clk = ~sys_clk;
    pmi_bus_if pmi_bus_if_i ();
    pmi_slave pmi_slave_i (.sys_clk(sys_clk), .reset_n(reset_n), .bus(pmi_bus_if_i),
        .addr_strap_low(addr_strap_low), .addr_strap_high(addr_strap_high), .volt_result(volt_result),
        .curr_result(curr_result), .results_ready(results_ready), .cmd_byte(cmd_byte),
        .cmd_strobe(cmd_strobe), .ext_strobe(ext_strobe), .ext_data(ext_data), .ext_data_strobe(ext_data_strobe));
    pmi_master pmi_master_i (.sys_clk(sys_clk), .reset_n(reset_n), .bus(pmi_bus_if_i),
        .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_cmd(req_cmd),
        .req_len(req_len), .busy(busy), .done(done), .nack(nack), .rd_data(rd_data));
    pmi_bus_checker pmi_bus_checker_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .scl_o(pmi_bus_if_i.scl_o), .scl_oe(pmi_bus_if_i.scl_oe), .sda_m_o(pmi_bus_if_i.sda_m_o),
        .sda_m_oe(pmi_bus_if_i.sda_m_oe), .sda_s_o(pmi_bus_if_i.sda_s_o), .sda_s_oe(pmi_bus_if_i.sda_s_oe),
        .scl_line(pmi_bus_if_i.scl_line), .sda_line(pmi_bus_if_i.sda_line));
    // ==========================================================
    // Wire monitor: address byte, its acknowledge slot and strobe counts.
    always @(posedge sys_clk) begin
        scl_d <= pmi_bus_if_i.scl_line;
        sda_d <= pmi_bus_if_i.sda_line;
        if (cmd_strobe === 1'b1) cmd_cnt++;
        if (ext_strobe === 1'b1) ext_cnt++;
        if (ext_data_strobe === 1'b1) ext_d_cnt++;
        if (scl_d && pmi_bus_if_i.scl_line && sda_d && !pmi_bus_if_i.sda_line) begin
            mon_cnt <= 0;
        end else if (!scl_d && pmi_bus_if_i.scl_line) begin
            mon_cnt <= mon_cnt + 1;
            if (mon_cnt < 8) mon_sh <= {mon_sh[6:0], pmi_bus_if_i.sda_line};
            if (mon_cnt == 8) mon_ack <= pmi_bus_if_i.sda_line;
        end
    end
    // ==========================================================
    // Shared tasks.
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic do_reset;
        reset_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic do_txn(input pmi_op_type op, input logic [6:0] a, input logic [7:0] c, input logic [1:0] n);
        int k;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_cmd <= c;
        req_len <= n;
        k = 0;
        while (busy !== 1'b1 && k < 200) begin
            @(posedge sys_clk);
            k++;
        end
        req_valid <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 10000) begin
            @(posedge sys_clk);
            k++;
        end
        chk(24'(k < 10000), 24'h1);
        @(posedge sys_clk);
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_straps;
        logic [6:0] own;
        for (int i = 0; i < 16; i++) begin
            own = {3'h4, 4'(i)};
            addr_strap_high <= own[3:2];
            addr_strap_low <= own[1:0];
            do_reset;
            do_txn(PMI_OP_QUICK, own, 8'h00, 2'h0);
            chk(24'(nack), 24'h0);
            chk(24'(mon_sh), 24'(8'h80 + 8'(2 * i)));
            chk(24'(mon_ack), 24'h0);
            do_txn(PMI_OP_QUICK, own ^ (7'h01 << (i % 7)), 8'h00, 2'h0);
            chk(24'(nack), 24'h1);
        end
    endtask
    task automatic t_write;
        logic [7:0] cmds [2] = '{8'h05, 8'h83};
        addr_strap_low <= 2'h0;
        for (int j = 0; j < 2; j++) begin
            cmd_cnt = 0;
            ext_cnt = 0;
            ext_d_cnt = 0;
            do_txn(PMI_OP_WRITE, 7'h4f, cmds[j], {1'b0, cmds[j][7]});
            chk(24'(nack), 24'h0);
            chk(24'(cmd_byte), 24'(cmds[j]));
            chk(24'(cmd_cnt), 24'(!cmds[j][7]));
            chk(24'(ext_cnt), 24'(cmds[j][7]));
            chk(24'(ext_d_cnt), 24'(cmds[j][7]));
            chk(24'(ext_data), 24'(cmds[j][7] ? cmds[j] : 8'h00));
        end
    endtask
    task automatic t_read;
        volt_result <= 12'habc;
        curr_result <= 12'h123;
        results_ready <= 1'b1;
        do_txn(PMI_OP_WRITE, 7'h4f, 8'h05, 2'h0);
        do_txn(PMI_OP_READ, 7'h4f, 8'h00, 2'h2);
        chk(24'(nack), 24'h0);
        chk(24'(mon_sh), 24'h9f);
        chk(24'(rd_data[15:0]), 24'h00abc1);
        do_txn(PMI_OP_READ, 7'h4f, 8'h00, 2'h3);
        chk(rd_data, 24'habc123);
        results_ready <= 1'b0;
        do_txn(PMI_OP_READ, 7'h4f, 8'h00, 2'h3);
        chk(24'(nack), 24'h1);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Main sequence and watchdog.
    initial begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_straps;
        t_write;
        t_read;
        test_done;
    end
    initial begin
        repeat (90000) @(posedge sys_clk);
        err_count++;
        test_done;
    end
endmodule
